// ### verilog/adc_link_regs.svh
// Constants for the converter serial link: timing counts, bit positions.
// Assumes a 125 MHz host core clock and a 15 ns device link clock.
`ifndef ADC_LINK_REGS_SVH
`define ADC_LINK_REGS_SVH

`define WORD_BITS        16
`define WORD_MSB         15
`define LAST_FALL        4'hF
`define CONV_MIN_CYC     8'h28
`define CONV_MAX_CYC     8'h3C
`define CORE_CLK_MHZ     125
`define T_CONV_WAIT_NS   1000
`define CONV_WAIT_CYC    8'(((`T_CONV_WAIT_NS * `CORE_CLK_MHZ) + 999) / 1000)
`define ARM_CYC          8'h04
`define SCLK_HALF_CYC    8'h08
`define GAP_CYC          8'h10
`define LFSR_SEED        8'h01
`define SYNC_CONV        2
`define SYNC_SEL         1
`define SYNC_SCLK        0
// Synchroniser reset level equals the idle pins: start low, select high
`define PIN_IDLE         3'h2

`endif

// ### verilog/adc_link_pkg.sv
// Types shared by both ends of the converter serial link.
// Assumes adc_link_regs.svh supplies the numeric constants.
package adc_link_pkg;

  typedef enum logic [1:0] {
    MODE_3WIRE = 2'h0,
    MODE_4WIRE = 2'h1,
    MODE_DAISY = 2'h2
  } link_mode_e;

  typedef enum logic [1:0] {
    DEV_ACQ  = 2'h1,
    DEV_CONV = 2'h2
  } dev_state_e;

  typedef enum logic [5:0] {
    HST_IDLE   = 6'h01,
    HST_ARM    = 6'h02,
    HST_CONV   = 6'h04,
    HST_READ   = 6'h08,
    HST_FINISH = 6'h10,
    HST_GAP    = 6'h20
  } host_state_e;

endpackage

// ### verilog/adc_serial_if.sv
// Pins between the converter and its serial host.
// The host samples serial_out through two flip-flops; only the bench looks at serial_out_oe.
`timescale 1ns/1ps
interface adc_serial_if;
  logic convert_start;
  logic host_serial_input;
  logic serial_clk;
  logic serial_out;
  logic serial_out_oe;

  modport device (
    input  convert_start,
    input  host_serial_input,
    input  serial_clk,
    output serial_out,
    output serial_out_oe
  );

  modport host (
    output convert_start,
    output host_serial_input,
    output serial_clk,
    input  serial_out,
    input  serial_out_oe
  );
endinterface

// ### verilog/sar_adc_device.sv
// Converter end: conversion sequencing and serial result readout.
// Runs wholly on LINK_CLK_IN; all link pins pass two flip-flops first.
// SAMPLE_IN is assumed synchronous to LINK_CLK_IN.
`timescale 1ns/1ps
`include "adc_link_regs.svh"
module sar_adc_device
  import adc_link_pkg::*;
(
  input  wire logic        LINK_CLK_IN,
  input  wire logic        NRST_IN,
  input  wire logic [15:0] SAMPLE_IN,
  adc_serial_if.device     LINK,
  output wire logic        POWERED_UP_OUT,
  output wire logic        DAISY_MODE_OUT,
  output wire logic        RESULT_READY_OUT
);

  logic [2:0]  meta_q;
  logic [2:0]  sync_q;
  logic [2:0]  prev_q;
  dev_state_e  state_q;
  logic [7:0]  conv_cnt_q;
  logic [7:0]  lfsr_q;
  logic [15:0] captured_q;
  logic [15:0] shift_q;
  logic        daisy_q;
  logic        have_q;
  logic        reading_q;
  logic        cs3_q;
  logic [3:0]  fall_cnt_q;
  logic        drive_q;
  logic        sdo_q;
  logic        out_q;
  logic        oe_q;

  logic        conv_s;
  logic        sel_s;
  logic        conv_rise;
  logic        conv_fall;
  logic        sel_rise;
  logic        sel_fall;
  logic        sclk_fall;
  logic        conv_done;
  logic [7:0]  conv_len;

  always_ff @(posedge LINK_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      // A zero here would look like both pins low and a select edge
      meta_q <= `PIN_IDLE;
      sync_q <= `PIN_IDLE;
      prev_q <= `PIN_IDLE;
    end else begin
      meta_q <= {LINK.convert_start, LINK.host_serial_input, LINK.serial_clk};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign conv_s    = sync_q[`SYNC_CONV];
  assign sel_s     = sync_q[`SYNC_SEL];
  assign conv_rise = conv_s & ~prev_q[`SYNC_CONV];
  assign conv_fall = ~conv_s & prev_q[`SYNC_CONV];
  assign sel_rise  = sel_s & ~prev_q[`SYNC_SEL];
  assign sel_fall  = ~sel_s & prev_q[`SYNC_SEL];
  assign sclk_fall = ~sync_q[`SYNC_SCLK] & prev_q[`SYNC_SCLK];

  // Pseudo-random length so the host cannot rely on one fixed figure
  always_ff @(posedge LINK_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      lfsr_q <= `LFSR_SEED;
    end else begin
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    end
  end

  assign conv_len = `CONV_MIN_CYC +
                    (lfsr_q % (`CONV_MAX_CYC - `CONV_MIN_CYC + 8'h01));
  assign conv_done = (state_q == DEV_CONV) && (conv_cnt_q == 8'h01);

  always_ff @(posedge LINK_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      state_q    <= DEV_ACQ;
      conv_cnt_q <= 8'h00;
      daisy_q    <= 1'b0;
      captured_q <= 16'h0000;
    end else begin
      case (state_q)
        DEV_ACQ: begin
          if (conv_rise) begin
            state_q    <= DEV_CONV;
            daisy_q    <= ~sel_s;
            conv_cnt_q <= conv_len;
            captured_q <= SAMPLE_IN;
          end
        end
        DEV_CONV: begin
          // Pins are ignored here; only the count ends the conversion
          if (conv_done) begin
            state_q <= DEV_ACQ;
          end else begin
            conv_cnt_q <= conv_cnt_q - 8'h01;
          end
        end
        default: begin
          state_q <= DEV_ACQ;
        end
      endcase
    end
  end

  always_ff @(posedge LINK_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      shift_q    <= 16'h0000;
      have_q     <= 1'b0;
      reading_q  <= 1'b0;
      cs3_q      <= 1'b0;
      fall_cnt_q <= 4'h0;
      drive_q    <= 1'b0;
      sdo_q      <= 1'b0;
    end else if ((state_q == DEV_ACQ) && conv_rise) begin
      drive_q   <= ~sel_s;
      sdo_q     <= 1'b0;
      reading_q <= 1'b0;
      have_q    <= 1'b0;
    end else if (conv_done) begin
      shift_q <= captured_q;
      have_q  <= ~daisy_q;
      if (daisy_q) begin
        sdo_q   <= captured_q[`WORD_MSB];
        drive_q <= 1'b1;
      end
    end else if (state_q == DEV_ACQ) begin
      if (daisy_q) begin
        if (sclk_fall) begin
          shift_q <= {shift_q[`WORD_MSB-1:0], sel_s};
          sdo_q   <= shift_q[`WORD_MSB-1];
        end
      end else if (reading_q) begin
        if (!cs3_q && sel_rise) begin
          drive_q   <= 1'b0;
          reading_q <= 1'b0;
        end else if (sclk_fall) begin
          if (fall_cnt_q == `LAST_FALL) begin
            drive_q   <= 1'b0;
            reading_q <= 1'b0;
          end else begin
            shift_q    <= {shift_q[`WORD_MSB-1:0], 1'b0};
            sdo_q      <= shift_q[`WORD_MSB-1];
            fall_cnt_q <= fall_cnt_q + 4'h1;
          end
        end
      end else if (have_q && ((conv_fall && sel_s) || (sel_fall && conv_s))) begin
        drive_q    <= 1'b1;
        sdo_q      <= shift_q[`WORD_MSB];
        reading_q  <= 1'b1;
        have_q     <= 1'b0;
        cs3_q      <= conv_fall;
        fall_cnt_q <= 4'h0;
      end
    end
  end

  // Both pins low overrides whatever the shifter wants to show
  always_ff @(posedge LINK_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      out_q <= 1'b0;
      oe_q  <= 1'b0;
    end else if (!conv_s && !sel_s) begin
      out_q <= 1'b0;
      oe_q  <= 1'b1;
    end else begin
      out_q <= sdo_q;
      oe_q  <= drive_q;
    end
  end

  assign LINK.serial_out    = out_q;
  assign LINK.serial_out_oe = oe_q;
  assign POWERED_UP_OUT     = (state_q == DEV_CONV);
  assign DAISY_MODE_OUT     = daisy_q;
  assign RESULT_READY_OUT   = have_q;

endmodule // sar_adc_device

// ### verilog/sar_adc_host.sv
// Host end: starts conversions and reads results over the serial link.
// Makes the serial clock from CORE_CLK_IN; serial_out is synchronised.
// Single device on the line in the chip-select options.
`timescale 1ns/1ps
`include "adc_link_regs.svh"
module sar_adc_host
  import adc_link_pkg::*;
(
  input  wire logic        CORE_CLK_IN,
  input  wire logic        NRST_IN,
  input  wire logic        START_IN,
  input  wire logic [1:0]  MODE_IN,
  input  wire logic [3:0]  CHAIN_LEN_IN,
  adc_serial_if.host       LINK,
  output wire logic        BUSY_OUT,
  output wire logic [15:0] DATA_OUT,
  output wire logic        DATA_VALID_OUT
);

  logic        sdo_meta_q;
  logic        sdo_sync_q;
  host_state_e state_q;
  link_mode_e  mode_q;
  logic [4:0]  len_q;
  logic [7:0]  timer_q;
  logic [3:0]  bit_q;
  logic [4:0]  word_q;
  logic        sclk_q;
  logic        conv_q;
  logic        sel_q;
  logic [15:0] shift_q;
  logic [15:0] data_q;
  logic        valid_q;

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      sdo_meta_q <= 1'b0;
      sdo_sync_q <= 1'b0;
    end else begin
      sdo_meta_q <= LINK.serial_out;
      sdo_sync_q <= sdo_meta_q;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      state_q <= HST_IDLE;
      mode_q  <= MODE_3WIRE;
      len_q   <= 5'h01;
      timer_q <= 8'h00;
      bit_q   <= 4'h0;
      word_q  <= 5'h00;
      sclk_q  <= 1'b0;
      conv_q  <= 1'b0;
      sel_q   <= 1'b1;
      shift_q <= 16'h0000;
      data_q  <= 16'h0000;
      valid_q <= 1'b0;
    end else begin
      valid_q <= 1'b0;
      case (state_q)
        HST_IDLE: begin
          if (START_IN) begin
            mode_q  <= link_mode_e'(MODE_IN);
            len_q   <= (CHAIN_LEN_IN == 4'h0) ? 5'h01 : {1'b0, CHAIN_LEN_IN};
            sel_q   <= (MODE_IN != MODE_DAISY);
            timer_q <= `ARM_CYC;
            state_q <= HST_ARM;
          end
        end
        HST_ARM: begin
          if (timer_q == 8'h00) begin
            conv_q  <= 1'b1;
            timer_q <= `CONV_WAIT_CYC;
            state_q <= HST_CONV;
          end else begin
            timer_q <= timer_q - 8'h01;
          end
        end
        HST_CONV: begin
          // Start stays high through the whole worst-case window; select too, except in daisy mode where it is low
          if (timer_q == 8'h00) begin
            if (mode_q == MODE_3WIRE) begin
              conv_q <= 1'b0;
            end
            if (mode_q == MODE_4WIRE) begin
              sel_q <= 1'b0;
            end
            timer_q <= `SCLK_HALF_CYC - 8'h01;
            bit_q   <= 4'h0;
            word_q  <= 5'h00;
            state_q <= HST_READ;
          end else begin
            timer_q <= timer_q - 8'h01;
          end
        end
        HST_READ: begin
          if (timer_q != 8'h00) begin
            timer_q <= timer_q - 8'h01;
          end else begin
            timer_q <= `SCLK_HALF_CYC - 8'h01;
            if (!sclk_q) begin
              sclk_q <= 1'b1;
            end else begin
              // Capture just before the fall that moves the next bit out
              sclk_q  <= 1'b0;
              shift_q <= {shift_q[`WORD_MSB-1:0], sdo_sync_q};
              bit_q   <= bit_q + 4'h1;
              if (bit_q == `LAST_FALL) begin
                data_q  <= {shift_q[`WORD_MSB-1:0], sdo_sync_q};
                valid_q <= 1'b1;
                word_q  <= word_q + 5'h01;
                if ((word_q + 5'h01) >= len_q) begin
                  state_q <= HST_FINISH;
                end
              end
            end
          end
        end
        HST_FINISH: begin
          if (mode_q == MODE_4WIRE) begin
            sel_q <= 1'b1;
          end
          timer_q <= `GAP_CYC;
          state_q <= HST_GAP;
        end
        HST_GAP: begin
          conv_q <= 1'b0;
          if (timer_q == 8'h00) begin
            state_q <= HST_IDLE;
          end else begin
            timer_q <= timer_q - 8'h01;
          end
        end
        default: begin
          state_q <= HST_IDLE;
        end
      endcase
    end
  end

  assign LINK.convert_start     = conv_q;
  assign LINK.host_serial_input = sel_q;
  assign LINK.serial_clk        = sclk_q;
  assign BUSY_OUT               = (state_q != HST_IDLE);
  assign DATA_OUT               = data_q;
  assign DATA_VALID_OUT         = valid_q;

endmodule // sar_adc_host

// ### tb/adc_link_monitor.sv
// Assertions on the serial link pins between host and converter ends.
// Assumes one shared active-low reset and one device on the link.
`timescale 1ns/1ps
module adc_link_monitor (
  input wire logic LINK_CLK_IN,
  input wire logic CORE_CLK_IN,
  input wire logic NRST_IN,
  input wire logic convert_start,
  input wire logic host_serial_input,
  input wire logic serial_clk,
  input wire logic serial_out,
  input wire logic serial_out_oe
);
  // Longest conversion in core cycles, rounded up
  localparam int CONV_MAX_CORE = 113;
  logic       cs_l_q;
  logic       four_q;
  logic       sclk_l_q;
  logic [4:0] falls_q;
  logic       cs_c_q;
  logic [7:0] hi_cnt_q;

  always_ff @(posedge LINK_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      cs_l_q <= 1'b0;
      four_q <= 1'b0;
    end else if ($rose(convert_start)) begin
      cs_l_q <= host_serial_input;
      four_q <= 1'b0;
    end else if (cs_l_q && convert_start && $fell(host_serial_input)) begin
      four_q <= 1'b1;
    end
  end

  // Falls counted only while the line is driven
  always_ff @(posedge LINK_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      sclk_l_q <= 1'b0;
      falls_q  <= 5'h00;
    end else begin
      sclk_l_q <= serial_clk;
      if (!serial_out_oe) falls_q <= 5'h00;
      else if (sclk_l_q && !serial_clk && falls_q != 5'h1F)
        falls_q <= falls_q + 5'h01;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) cs_c_q <= 1'b0;
    else if ($rose(convert_start)) cs_c_q <= host_serial_input;
    else if ($fell(convert_start)) cs_c_q <= 1'b0;
  end

  // Saturates so a long hold never wraps to a small count
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) hi_cnt_q <= 8'h00;
    else if (!convert_start) hi_cnt_q <= 8'h00;
    else if (hi_cnt_q != 8'hFF) hi_cnt_q <= hi_cnt_q + 8'h01;
  end

  start_tristate_a: assert property (@(posedge LINK_CLK_IN)
    disable iff (!NRST_IN) $rose(convert_start) && host_serial_input
    |-> ##[1:8] !serial_out_oe) else $error("output not released at start");
  three_read_a: assert property (@(posedge LINK_CLK_IN)
    disable iff (!NRST_IN) cs_l_q && !four_q && $fell(convert_start)
    |-> ##[2:8] serial_out_oe) else $error("3-wire read did not drive");
  four_read_a: assert property (@(posedge LINK_CLK_IN)
    disable iff (!NRST_IN) cs_l_q && convert_start && $fell(host_serial_input)
    |-> ##[2:8] serial_out_oe) else $error("4-wire read did not drive");
  four_sel_end_a: assert property (@(posedge LINK_CLK_IN)
    disable iff (!NRST_IN) four_q && $rose(host_serial_input)
    |-> ##[1:8] !serial_out_oe) else $error("select rise kept output");
  sixteen_end_a: assert property (@(posedge LINK_CLK_IN)
    disable iff (!NRST_IN) cs_l_q && falls_q == 5'h10
    |-> ##[1:8] !serial_out_oe) else $error("output held past 16 falls");
  both_low_a: assert property (@(posedge LINK_CLK_IN)
    disable iff (!NRST_IN) (!convert_start && !host_serial_input)[*6]
    |-> serial_out_oe && !serial_out) else $error("both low not driven low");
  daisy_drive_a: assert property (@(posedge LINK_CLK_IN)
    disable iff (!NRST_IN) $rose(convert_start) && !host_serial_input
    |-> ##[2:10] serial_out_oe) else $error("daisy output not driven");
  conv_hold_a: assert property (@(posedge CORE_CLK_IN)
    disable iff (!NRST_IN) $fell(convert_start)
    |-> hi_cnt_q >= CONV_MAX_CORE) else $error("start dropped too early");
  sel_hold_a: assert property (@(posedge CORE_CLK_IN)
    disable iff (!NRST_IN) cs_c_q && convert_start && $fell(host_serial_input)
    |-> hi_cnt_q >= CONV_MAX_CORE && !serial_out_oe)
    else $error("select fell too early or onto a driven line");
  start_clk_low_a: assert property (@(posedge CORE_CLK_IN)
    disable iff (!NRST_IN) $rose(convert_start) |-> !serial_clk)
    else $error("serial clock high at start");
  never_both_low_a: assert property (@(posedge CORE_CLK_IN)
    disable iff (!NRST_IN) cs_c_q && $fell(convert_start)
    |-> host_serial_input) else $error("start fell with select low");
endmodule // adc_link_monitor

// ### tb/sar_adc_serial_readout_test.sv
// Bench joining host and converter ends over one link interface.
// Assumes a single converter; daisy reads beyond it return shifted zeros.
`timescale 1ns/1ps
module sar_adc_serial_readout_test
  import adc_link_pkg::*;
;
  logic        core_clk, link_clk, nrst, start, busy, valid;
  logic        pwr_up, daisy, ready;
  logic [1:0]  mode;
  logic [3:0]  chain_len;
  logic [15:0] sample, data;
  int          errors, compares;

  adc_serial_if link_if();
  sar_adc_host sar_adc_host_i(.CORE_CLK_IN(core_clk), .NRST_IN(nrst),
    .START_IN(start), .MODE_IN(mode), .CHAIN_LEN_IN(chain_len),
    .LINK(link_if.host), .BUSY_OUT(busy), .DATA_OUT(data),
    .DATA_VALID_OUT(valid));
  sar_adc_device sar_adc_device_i(.LINK_CLK_IN(link_clk), .NRST_IN(nrst),
    .SAMPLE_IN(sample), .LINK(link_if.device), .POWERED_UP_OUT(pwr_up),
    .DAISY_MODE_OUT(daisy), .RESULT_READY_OUT(ready));
  adc_link_monitor adc_link_monitor_i(.LINK_CLK_IN(link_clk),
    .CORE_CLK_IN(core_clk), .NRST_IN(nrst),
    .convert_start(link_if.convert_start),
    .host_serial_input(link_if.host_serial_input),
    .serial_clk(link_if.serial_clk), .serial_out(link_if.serial_out),
    .serial_out_oe(link_if.serial_out_oe));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // Odd offset keeps the link clock out of phase with the core
  initial begin
    link_clk = 1'b0;
    #3.3;
    forever #7.5 link_clk = ~link_clk;
  end

  task automatic end_of_test();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp,
                     input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic guard(input int n, input int lim);
    if (n >= lim) begin
      errors++;
      $display("ERROR timeout expected below %0d seen %0d", lim, n);
      end_of_test();
    end
  endtask

  // One conversion and readout; a start during busy must be ignored
  task automatic run(input logic [1:0] m, input logic [3:0] len,
                     input logic [15:0] w);
    int n;
    int k;
    @(posedge link_clk);
    #1 sample = w;
    @(posedge core_clk);
    #1 mode = m;
    chain_len = len;
    start = 1'b1;
    @(posedge core_clk);
    #1 start = 1'b0;
    n = 0;
    while (pwr_up !== 1'b1 && n < 200) begin @(posedge core_clk); #1; n++; end
    guard(n, 200);
    n = 0;
    while (pwr_up === 1'b1 && n < 200) begin @(posedge core_clk); #1; n++; end
    guard(n, 200);
    chk("conv_in_range", 16'h0001, {15'h0000, n >= 74 && n <= 114});
    chk("daisy_mode", {15'h0000, m == MODE_DAISY}, {15'h0000, daisy});
    chk("result_held", {15'h0000, m != MODE_DAISY}, {15'h0000, ready});
    for (k = 0; k < len; k++) begin
      n = 0;
      while (valid !== 1'b1 && n < 600) begin @(posedge core_clk); #1; n++; end
      guard(n, 600);
      chk("data_word", (k == 0) ? w : 16'h0000, data);
      @(posedge core_clk);
      #1;
    end
    start = 1'b1;
    @(posedge core_clk);
    #1 start = 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 600) begin @(posedge core_clk); #1; n++; end
    guard(n, 600);
    chk("result_ready", 16'h0000, {15'h0000, ready});
    chk("powered_up", 16'h0000, {15'h0000, pwr_up});
    repeat (3) @(posedge core_clk);
    #1;
    chk("busy_after_refused", 16'h0000, {15'h0000, busy});
  endtask

  initial begin
    nrst = 1'b0;
    start = 1'b0;
    mode = MODE_3WIRE;
    chain_len = 4'h1;
    sample = 16'h0000;
    errors = 0;
    compares = 0;
    repeat (12) @(posedge core_clk);
    #1 nrst = 1'b1;
    // Look while the device synchronisers settle on the idle pins
    repeat (4) @(posedge core_clk);
    #1;
    chk("reset_oe", 16'h0000, {15'h0000, link_if.serial_out_oe});
    run(MODE_3WIRE, 4'h1, 16'h8000);
    run(MODE_3WIRE, 4'h1, 16'h0001);
    run(MODE_4WIRE, 4'h1, 16'h7FFF);
    run(MODE_DAISY, 4'h2, 16'hA5C3);
    run(MODE_4WIRE, 4'h1, 16'hFFFF);
    end_of_test();
  end
endmodule // sar_adc_serial_readout_test
